/* File: inc/acm_consts.svh */
// Purpose: Register numbers, field values and timing constants of the actuator register logic
// Assumes: Register numbers are the word addresses used on the link
// Notes:   Included by its bare name
`ifndef ACM_CONSTS_SVH
`define ACM_CONSTS_SVH

// ----------------------------------------------------------------
// Holding registers
// ----------------------------------------------------------------
`define ACM_HR_TARGET_POSITION   16'h0001
`define ACM_HR_REMOTE_COMMAND    16'h0002
`define ACM_HR_SCHED_LO          16'h0004
`define ACM_HR_SCHED_HI          16'h0005
`define ACM_HR_CLOCK_LO          16'h000a
`define ACM_HR_CLOCK_HI          16'h000b
`define ACM_HR_IN_MAP_SELECT     16'h03e9
`define ACM_HR_IN_MAP_VALUE      16'h03ea
`define ACM_HR_HOLD_MAP_SELECT   16'h03eb
`define ACM_HR_HOLD_MAP_VALUE    16'h03ec
`define ACM_HR_MAP_COMMAND       16'h03ed

// ----------------------------------------------------------------
// Input registers
// ----------------------------------------------------------------
`define ACM_IR_RUN_STATUS        16'h0001
`define ACM_IR_POWER_FAIL        16'h001a
`define ACM_IR_INWARD_STARTS     16'h001c
`define ACM_IR_OUTWARD_STARTS    16'h001e
`define ACM_IR_RUNNING_SECONDS   16'h0020
`define ACM_IR_PEAK_CURRENT      16'h0022
`define ACM_IR_PEAK_SWITCH_TEMP  16'h0023
`define ACM_IR_MIN_BODY_TEMP     16'h0024
`define ACM_IR_WORK_DONE         16'h0025
`define ACM_IR_BAD_CONTENT       16'h0027
`define ACM_IR_CRC_ERROR         16'h0029
`define ACM_IR_OUTWARD_CUTOFF    16'h002b
`define ACM_IR_INWARD_CUTOFF     16'h002d
`define ACM_IR_OVERTEMP_RUNS     16'h002f

// ----------------------------------------------------------------
// Values and resets
// ----------------------------------------------------------------
`define ACM_CMD_RUN_SCHEDULED    16'h0003
`define ACM_RUN_STATUS_WAITING   16'h0003
`define ACM_RUN_STATUS_IDLE      16'h0000
`define ACM_MAP_CMD_SAVE         16'h0001
`define ACM_MAP_CMD_DEFAULT      16'h0002
`define ACM_MIN_TEMP_RESET       16'h7fff
`define ACM_SECONDS_WRAP         16'h003b

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define ACM_CLOCK_HZ             25000000
`define ACM_SECOND_S             1
`define ACM_SECOND_CYCLES        (`ACM_CLOCK_HZ * `ACM_SECOND_S)

`endif

/* File: inc/acm_pkg.sv */
// Purpose: Types shared by the actuator register logic and its neighbours
// Assumes: One request per cycle at most from the frame engine
// Notes:   Constants live in acm_consts.svh
package acm_pkg;

	// ----------------------------------------------------------------
	// Register request from the frame engine
	// ----------------------------------------------------------------
	typedef struct packed {
		logic        is_input;
		logic        write;
		logic        broadcast;
		logic [15:0] addr;
		logic [15:0] wdata;
	} acm_req_s;

	// ----------------------------------------------------------------
	// Answer to a register request
	// ----------------------------------------------------------------
	typedef struct packed {
		logic        valid;
		logic        error;
		logic [15:0] data;
	} acm_rsp_s;

	// ----------------------------------------------------------------
	// Service events, one-cycle pulses
	// ----------------------------------------------------------------
	typedef struct packed {
		logic power_fail;
		logic start_in;
		logic start_out;
		logic run_second;
		logic work_unit;
		logic bad_content;
		logic crc_error;
		logic cutoff_out;
		logic cutoff_in;
		logic overtemp_run;
	} acm_evt_s;

endpackage

/* File: core/acm_regs.sv */
// Purpose: Register bank of the actuator: scheduled start, service counters, register remapping
// Assumes: Requests and events come from logic on i_clock
// Notes:   Mapping tables start at identity after reset and after a restore
`timescale 1ns/1ps
`include "acm_consts.svh"

module acm_regs #(
	parameter int MAP_DEPTH  = 128,
	parameter int SEC_CYCLES = `ACM_SECOND_CYCLES
) (
	input  wire logic              i_clock,        // System clock
	input  wire logic              i_arst_n,       // Asynchronous reset, low
	input  wire logic              i_req_valid,    // Request strobe
	input  wire acm_pkg::acm_req_s i_req,          // Request fields
	input  wire acm_pkg::acm_evt_s i_evt,          // Service event pulses
	input  wire logic [15:0]       i_current_ma,   // Motor current sample
	input  wire logic [15:0]       i_switch_temp,  // Switch temperature, signed
	input  wire logic [15:0]       i_body_temp,    // Body temperature, signed
	input  wire logic [15:0]       i_run_status,   // Motion run status
	output logic                   o_rsp_valid,    // Answer strobe
	output logic                   o_rsp_error,    // Illegal address or value
	output logic [15:0]            o_rsp_data,     // Read data
	output logic [15:0]            o_target_pos,   // Target, tenths of mm
	output logic                   o_cmd_strobe,   // Remote command written
	output logic [15:0]            o_cmd_value,    // Remote command value
	output logic                   o_start_move,   // Scheduled start pulse
	output logic                   o_armed,        // Waiting for trigger
	output logic                   o_map_save      // Save mapping pulse
);
	import acm_pkg::*;

	localparam int MAP_AW = $clog2(MAP_DEPTH);
	localparam int TICK_W = $clog2(SEC_CYCLES + 1);

	// Elaboration checks on the parameters
	if (MAP_DEPTH < 64 || MAP_DEPTH > 256 || (1 << MAP_AW) != MAP_DEPTH)
		$error("MAP_DEPTH must be a power of two from 64 to 256");
	if (SEC_CYCLES < 2)
		$error("SEC_CYCLES must be at least 2");

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [MAP_DEPTH-1:0][7:0] in_map;
		logic [MAP_DEPTH-1:0][7:0] hold_map;
		logic [15:0]               in_select;
		logic [15:0]               hold_select;
		logic [15:0]               target_pos;
		logic [15:0]               cmd_value;
		logic [15:0]               sched_lo;
		logic [15:0]               sched_hi;
		logic [15:0]               clock_lo;
		logic [15:0]               clock_hi;
		logic [TICK_W-1:0]         tick;
		logic                      armed;
		logic [31:0]               power_fail;
		logic [31:0]               starts_in;
		logic [31:0]               starts_out;
		logic [31:0]               run_seconds;
		logic [15:0]               peak_current;
		logic [15:0]               peak_switch;
		logic [15:0]               min_body;
		logic [31:0]               work_done;
		logic [31:0]               bad_content;
		logic [31:0]               crc_error;
		logic [31:0]               cutoff_out;
		logic [31:0]               cutoff_in;
		logic [15:0]               overtemp_runs;
		acm_rsp_s                  rsp;
		logic                      cmd_strobe;
		logic                      start_move;
		logic                      map_save;
	} acm_state_s;

	acm_state_s st;
	acm_state_s next_st;

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic logic [MAP_DEPTH-1:0][7:0] identity_map();
		logic [MAP_DEPTH-1:0][7:0] m;
		for (int i = 0; i < MAP_DEPTH; i++)
			m[i] = i[7:0];
		return m;
	endfunction

	function automatic logic in_range(input logic [15:0] addr);
		return addr < 16'(MAP_DEPTH);
	endfunction

	function automatic logic [15:0] word_hi(input logic [31:0] v);
		return v[31:16];
	endfunction

	// Default input register space, addressed by parameter reference
	function automatic logic [15:0] input_word(input acm_state_s s, input logic [7:0] ref_no,
		input logic [15:0] run_status);
		logic [15:0] r;
		r = 16'h0000;
		unique case (ref_no)
			`ACM_IR_RUN_STATUS:           r = s.armed ? `ACM_RUN_STATUS_WAITING : run_status;
			`ACM_IR_POWER_FAIL:           r = word_hi(s.power_fail);
			`ACM_IR_POWER_FAIL + 1:       r = s.power_fail[15:0];
			`ACM_IR_INWARD_STARTS:        r = word_hi(s.starts_in);
			`ACM_IR_INWARD_STARTS + 1:    r = s.starts_in[15:0];
			`ACM_IR_OUTWARD_STARTS:       r = word_hi(s.starts_out);
			`ACM_IR_OUTWARD_STARTS + 1:   r = s.starts_out[15:0];
			`ACM_IR_RUNNING_SECONDS:      r = word_hi(s.run_seconds);
			`ACM_IR_RUNNING_SECONDS + 1:  r = s.run_seconds[15:0];
			`ACM_IR_PEAK_CURRENT:         r = s.peak_current;
			`ACM_IR_PEAK_SWITCH_TEMP:     r = s.peak_switch;
			`ACM_IR_MIN_BODY_TEMP:        r = s.min_body;
			`ACM_IR_WORK_DONE:            r = word_hi(s.work_done);
			`ACM_IR_WORK_DONE + 1:        r = s.work_done[15:0];
			`ACM_IR_BAD_CONTENT:          r = word_hi(s.bad_content);
			`ACM_IR_BAD_CONTENT + 1:      r = s.bad_content[15:0];
			`ACM_IR_CRC_ERROR:            r = word_hi(s.crc_error);
			`ACM_IR_CRC_ERROR + 1:        r = s.crc_error[15:0];
			`ACM_IR_OUTWARD_CUTOFF:       r = word_hi(s.cutoff_out);
			`ACM_IR_OUTWARD_CUTOFF + 1:   r = s.cutoff_out[15:0];
			`ACM_IR_INWARD_CUTOFF:        r = word_hi(s.cutoff_in);
			`ACM_IR_INWARD_CUTOFF + 1:    r = s.cutoff_in[15:0];
			`ACM_IR_OVERTEMP_RUNS:        r = s.overtemp_runs;
			default:                      r = 16'h0000;
		endcase
		return r;
	endfunction

	// Default holding register space, addressed by parameter reference
	function automatic logic [15:0] hold_word(input acm_state_s s, input logic [7:0] ref_no);
		logic [15:0] r;
		r = 16'h0000;
		unique case (ref_no)
			`ACM_HR_TARGET_POSITION: r = s.target_pos;
			`ACM_HR_REMOTE_COMMAND:  r = s.cmd_value;
			`ACM_HR_SCHED_LO:        r = s.sched_lo;
			`ACM_HR_SCHED_HI:        r = s.sched_hi;
			`ACM_HR_CLOCK_LO:        r = s.clock_lo;
			`ACM_HR_CLOCK_HI:        r = s.clock_hi;
			default:                 r = 16'h0000;
		endcase
		return r;
	endfunction

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb
	begin
		logic        rd;
		logic        wr;
		logic [7:0]  ref_no;
		logic [15:0] a;
		logic        clock_written;
		next_st = st;
		next_st.rsp = '0;
		next_st.cmd_strobe = 1'b0;
		next_st.start_move = 1'b0;
		next_st.map_save = 1'b0;
		rd = i_req_valid && !i_req.write;
		wr = i_req_valid && i_req.write;
		a = i_req.addr;
		ref_no = 8'h00;
		clock_written = 1'b0;

		// Service counters: only events move them; peaks and minimum follow the samples
		if (i_evt.power_fail)   next_st.power_fail  = st.power_fail + 32'h1;
		if (i_evt.start_in)     next_st.starts_in   = st.starts_in + 32'h1;
		if (i_evt.start_out)    next_st.starts_out  = st.starts_out + 32'h1;
		if (i_evt.run_second)   next_st.run_seconds = st.run_seconds + 32'h1;
		if (i_evt.work_unit)    next_st.work_done   = st.work_done + 32'h1;
		if (i_evt.bad_content)  next_st.bad_content = st.bad_content + 32'h1;
		if (i_evt.crc_error)    next_st.crc_error   = st.crc_error + 32'h1;
		if (i_evt.cutoff_out)   next_st.cutoff_out  = st.cutoff_out + 32'h1;
		if (i_evt.cutoff_in)    next_st.cutoff_in   = st.cutoff_in + 32'h1;
		if (i_evt.overtemp_run) next_st.overtemp_runs = st.overtemp_runs + 16'h1;
		if (i_current_ma > st.peak_current)
			next_st.peak_current = i_current_ma;
		if ($signed(i_switch_temp) > $signed(st.peak_switch))
			next_st.peak_switch = i_switch_temp;
		if ($signed(i_body_temp) < $signed(st.min_body))
			next_st.min_body = i_body_temp;

		// Reads; a broadcast gets no answer
		if (rd && !i_req.broadcast)
		begin
			next_st.rsp.valid = 1'b1;
			if (i_req.is_input)
			begin
				if (in_range(a))
					next_st.rsp.data = input_word(st, st.in_map[a[MAP_AW-1:0]], i_run_status);
				else
					next_st.rsp.error = 1'b1;
			end
			else
			begin
				unique case (a)
					`ACM_HR_IN_MAP_SELECT:   next_st.rsp.data = st.in_select;
					`ACM_HR_IN_MAP_VALUE:
						next_st.rsp.data = {8'h00, st.in_map[st.in_select[MAP_AW-1:0]]};
					`ACM_HR_HOLD_MAP_SELECT: next_st.rsp.data = st.hold_select;
					`ACM_HR_HOLD_MAP_VALUE:
						next_st.rsp.data = {8'h00, st.hold_map[st.hold_select[MAP_AW-1:0]]};
					`ACM_HR_MAP_COMMAND:     next_st.rsp.data = 16'h0000;
					default:
					begin
						if (in_range(a))
							next_st.rsp.data = hold_word(st, st.hold_map[a[MAP_AW-1:0]]);
						else
							next_st.rsp.error = 1'b1;
					end
				endcase
			end
		end

		// Writes; input registers are read only
		if (wr)
		begin
			next_st.rsp.valid = !i_req.broadcast;
			if (i_req.is_input)
				next_st.rsp.error = 1'b1;
			else
			begin
				unique case (a)
					`ACM_HR_IN_MAP_SELECT:
					begin
						next_st.in_select = i_req.wdata;
						next_st.rsp.error = !in_range(i_req.wdata);
					end
					`ACM_HR_IN_MAP_VALUE:
					begin
						if (in_range(st.in_select) && i_req.wdata < 16'h0100)
							next_st.in_map[st.in_select[MAP_AW-1:0]] = i_req.wdata[7:0];
						else
							next_st.rsp.error = 1'b1;
					end
					`ACM_HR_HOLD_MAP_SELECT:
					begin
						next_st.hold_select = i_req.wdata;
						next_st.rsp.error = !in_range(i_req.wdata);
					end
					`ACM_HR_HOLD_MAP_VALUE:
					begin
						if (in_range(st.hold_select) && i_req.wdata < 16'h0100)
							next_st.hold_map[st.hold_select[MAP_AW-1:0]] = i_req.wdata[7:0];
						else
							next_st.rsp.error = 1'b1;
					end
					`ACM_HR_MAP_COMMAND:
					begin
						if (i_req.wdata == `ACM_MAP_CMD_SAVE)
							next_st.map_save = 1'b1;
						else if (i_req.wdata == `ACM_MAP_CMD_DEFAULT)
						begin
							next_st.in_map = identity_map();
							next_st.hold_map = identity_map();
						end
						else
							next_st.rsp.error = 1'b1;
					end
					default:
					begin
						if (in_range(a))
							ref_no = st.hold_map[a[MAP_AW-1:0]];
						else
							next_st.rsp.error = 1'b1;
					end
				endcase
			end
		end

		// Mapped holding parameters
		if (wr && !i_req.is_input && in_range(a))
		begin
			unique case (ref_no)
				`ACM_HR_TARGET_POSITION: next_st.target_pos = i_req.wdata;
				`ACM_HR_REMOTE_COMMAND:
				begin
					next_st.cmd_value = i_req.wdata;
					next_st.cmd_strobe = 1'b1;
					if (st.armed)
						next_st.armed = 1'b0;
					else
						next_st.armed = i_req.wdata == `ACM_CMD_RUN_SCHEDULED;
				end
				`ACM_HR_SCHED_LO:        next_st.sched_lo = i_req.wdata;
				`ACM_HR_SCHED_HI:        next_st.sched_hi = i_req.wdata;
				`ACM_HR_CLOCK_LO:
				begin
					next_st.clock_lo = i_req.wdata;
					clock_written = 1'b1;
				end
				`ACM_HR_CLOCK_HI:
				begin
					next_st.clock_hi = i_req.wdata;
					clock_written = 1'b1;
				end
				default:
				begin
				end
			endcase
		end

		// Seconds and minutes clock
		if (clock_written)
			next_st.tick = '0;
		else if (st.tick == TICK_W'(SEC_CYCLES - 1))
		begin
			next_st.tick = '0;
			if (st.clock_lo >= `ACM_SECONDS_WRAP)
			begin
				next_st.clock_lo = 16'h0000;
				next_st.clock_hi = st.clock_hi + 16'h1;
			end
			else
				next_st.clock_lo = st.clock_lo + 16'h1;
		end
		else
			next_st.tick = st.tick + TICK_W'(1);

		// Trigger compare on every cycle while armed
		if (st.armed && next_st.armed && st.sched_lo == st.clock_lo && st.sched_hi == st.clock_hi)
		begin
			next_st.armed = 1'b0;
			next_st.start_move = 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	always_ff @(posedge i_clock or negedge i_arst_n)
	begin
		if (!i_arst_n)
		begin
			st <= '0;
			st.in_map <= identity_map();
			st.hold_map <= identity_map();
			st.min_body <= `ACM_MIN_TEMP_RESET;
		end
		else
			st <= next_st;
	end

	assign o_rsp_valid  = st.rsp.valid;
	assign o_rsp_error  = st.rsp.error;
	assign o_rsp_data   = st.rsp.data;
	assign o_target_pos = st.target_pos;
	assign o_cmd_strobe = st.cmd_strobe;
	assign o_cmd_value  = st.cmd_value;
	assign o_start_move = st.start_move;
	assign o_armed      = st.armed;
	assign o_map_save   = st.map_save;

endmodule

/* File: verification/acm_regs_properties.sv */
// Purpose: Port checks of the actuator register bank
// Assumes: One clock domain, reset low
// Notes:   Bound to acm_regs from the testbench file
`timescale 1ns/1ps
`include "acm_consts.svh"
module acm_regs_checker #(
	parameter int MAP_DEPTH  = 128,
	parameter int SEC_CYCLES = 10
) (
	input wire logic              i_clock,      // Clock
	input wire logic              i_arst_n,     // Reset, low
	input wire logic              i_req_valid,  // Request strobe
	input wire acm_pkg::acm_req_s i_req,        // Request
	input wire logic [15:0]       i_run_status, // Run status
	input wire logic              o_rsp_valid,  // Answer strobe
	input wire logic              o_rsp_error,  // Answer error
	input wire logic [15:0]       o_rsp_data,   // Answer data
	input wire logic [15:0]       o_target_pos, // Target
	input wire logic              o_cmd_strobe, // Command pulse
	input wire logic [15:0]       o_cmd_value,  // Command value
	input wire logic              o_start_move, // Start pulse
	input wire logic              o_armed,      // Armed
	input wire logic              o_map_save    // Save pulse
);
	import acm_pkg::*;
	logic hw;
	logic cmd;
	logic save;
	assign hw   = i_req_valid && i_req.write && !i_req.is_input;
	assign cmd  = hw && i_req.addr == `ACM_HR_REMOTE_COMMAND;
	assign save = hw && i_req.addr == `ACM_HR_MAP_COMMAND && i_req.wdata == `ACM_MAP_CMD_SAVE;
	default clocking @(posedge i_clock); endclocking
	default disable iff (!i_arst_n);

	property p_answer; i_req_valid && !i_req.broadcast |=> o_rsp_valid; endproperty
	a_answer: assert property (p_answer)
		else $error("request got no answer");
	property p_silent; i_req_valid && i_req.broadcast |=> !o_rsp_valid; endproperty
	a_silent: assert property (p_silent)
		else $error("broadcast was answered");
	property p_arm;
		cmd && i_req.wdata == `ACM_CMD_RUN_SCHEDULED && !o_armed |=> o_armed && o_cmd_strobe;
	endproperty
	a_arm: assert property (p_arm)
		else $error("command 3 did not arm");
	property p_cancel; cmd && o_armed |=> !o_armed && !o_start_move && o_cmd_strobe; endproperty
	a_cancel: assert property (p_cancel)
		else $error("command write did not cancel");
	property p_start; o_start_move |-> $past(o_armed) && !o_armed; endproperty
	a_start: assert property (p_start)
		else $error("start without arming");
	property p_cmd_val; cmd |=> o_cmd_value == $past(i_req.wdata); endproperty
	a_cmd_val: assert property (p_cmd_val)
		else $error("command value wrong");
	property p_no_wr_in;
		i_req_valid && i_req.write && i_req.is_input && !i_req.broadcast |=> o_rsp_error;
	endproperty
	a_no_wr_in: assert property (p_no_wr_in)
		else $error("input write accepted");
	property p_target; hw && i_req.addr == `ACM_HR_TARGET_POSITION
		|=> o_target_pos == $past(i_req.wdata); endproperty
	a_target: assert property (p_target)
		else $error("target not stored");
	property p_save; o_map_save == $past(save); endproperty
	a_save: assert property (p_save)
		else $error("save pulse wrong");
	property p_status; i_req_valid && !i_req.write && i_req.is_input && !i_req.broadcast
		&& i_req.addr == `ACM_IR_RUN_STATUS |=> o_rsp_data == ($past(o_armed)
		? `ACM_RUN_STATUS_WAITING : $past(i_run_status)); endproperty
	a_status: assert property (p_status)
		else $error("run status wrong");
	property p_unmapped; i_req_valid && !i_req.broadcast && !i_req.is_input
		&& i_req.addr >= MAP_DEPTH && (i_req.addr < 16'h03e9 || i_req.addr > 16'h03ed)
		|=> o_rsp_valid && o_rsp_error; endproperty
	a_unmapped: assert property (p_unmapped)
		else $error("unmapped address accepted");
endmodule

/* File: verification/acm_ctrl_model.sv */
// Purpose: Controller model issuing register requests to the bank
// Assumes: Requests start 1 ns after a rising edge
// Notes:   Expected answers queued as check flag, error, data
`timescale 1ns/1ps
`include "acm_consts.svh"
module acm_ctrl_model (
	input  wire logic         i_clock,    // Clock
	output acm_pkg::acm_req_s o_req,      // Request fields
	output logic              o_req_valid // Request strobe
);
	import acm_pkg::*;
	logic [17:0] exp_q[$];
	initial
	begin
		o_req_valid = 1'b0;
		o_req = '0;
	end
	task automatic xfer(input logic inp, wr, bc, input logic [15:0] a, d,
		input logic e, ck, input logic [15:0] x);
		@(posedge i_clock);
		#1;
		o_req_valid = 1'b1;
		o_req = '{inp, wr, bc, a, d};
		if (!bc)
			exp_q.push_back({ck, e, x});
		@(posedge i_clock);
		#1;
		o_req_valid = 1'b0;
		// Released fields show garbage
		o_req = ~o_req;
	endtask
	task automatic wr(input logic [15:0] a, d);
		xfer(1'b0, 1'b1, 1'b0, a, d, 1'b0, 1'b0, 16'h0000);
	endtask
	task automatic rd(input logic inp, input logic [15:0] a, x);
		xfer(inp, 1'b0, 1'b0, a, 16'h0000, 1'b0, 1'b1, x);
	endtask
	// Caller keeps the trigger two seconds or more past the clock
	task automatic sched(input logic [15:0] tgt, cl, ch, tl, th);
		wr(`ACM_HR_TARGET_POSITION, tgt);
		xfer(1'b0, 1'b1, 1'b1, `ACM_HR_CLOCK_LO, cl, 1'b0, 1'b0, 16'h0000);
		xfer(1'b0, 1'b1, 1'b1, `ACM_HR_CLOCK_HI, ch, 1'b0, 1'b0, 16'h0000);
		wr(`ACM_HR_SCHED_LO, tl);
		wr(`ACM_HR_SCHED_HI, th);
		wr(`ACM_HR_REMOTE_COMMAND, `ACM_CMD_RUN_SCHEDULED);
	endtask
endmodule

/* File: verification/testbench.sv */
// Purpose: Self-checking bench of the actuator register bank
// Assumes: Second tick shortened to SC cycles
// Notes:   Monitor checks answers against queued notes
`timescale 1ns/1ps
`include "acm_consts.svh"
module testbench;
	import acm_pkg::*;
	localparam int SC = 10;
	logic               i_clock;
	logic               i_arst_n;
	logic               i_req_valid;
	acm_req_s           i_req;
	acm_evt_s           i_evt;
	logic [15:0]        i_current_ma;
	logic [15:0]        i_switch_temp;
	logic [15:0]        i_body_temp;
	logic [15:0]        i_run_status;
	logic               o_rsp_valid;
	logic               o_rsp_error;
	logic [15:0]        o_rsp_data;
	logic [15:0]        o_target_pos;
	logic               o_cmd_strobe;
	logic [15:0]        o_cmd_value;
	logic               o_start_move;
	logic               o_armed;
	logic               o_map_save;
	logic [17:0]        e;
	logic [15:0]        ir[26:47];
	logic [15:0]        pk_i;
	logic signed [15:0] pk_s;
	logic signed [15:0] mn_t;
	int                 cnt[10];
	int                 pr[9] = '{26, 28, 30, 32, 37, 39, 41, 43, 45};
	int                 fails;
	int                 total_checks;

	acm_regs #(.MAP_DEPTH(128), .SEC_CYCLES(SC)) i_acm_regs (.i_clock(i_clock),
		.i_arst_n(i_arst_n), .i_req_valid(i_req_valid), .i_req(i_req), .i_evt(i_evt),
		.i_current_ma(i_current_ma), .i_switch_temp(i_switch_temp),
		.i_body_temp(i_body_temp), .i_run_status(i_run_status), .o_rsp_valid(o_rsp_valid),
		.o_rsp_error(o_rsp_error), .o_rsp_data(o_rsp_data), .o_target_pos(o_target_pos),
		.o_cmd_strobe(o_cmd_strobe), .o_cmd_value(o_cmd_value),
		.o_start_move(o_start_move), .o_armed(o_armed), .o_map_save(o_map_save));
	acm_ctrl_model i_acm_ctrl_model (.i_clock(i_clock), .o_req(i_req),
		.o_req_valid(i_req_valid));

	initial i_clock = 1'b0;
	always #20 i_clock = ~i_clock;

	task automatic cmp_rsp(input logic [17:0] x, g);
		total_checks++;
		if (g !== x)
		begin
			fails++;
			$display("BAD t=%0t exp=%h got=%h", $time, x, g);
		end
	endtask
	task automatic cmp_lvl(input logic [15:0] x, g);
		cmp_rsp({2'b00, x}, {2'b00, g});
	endtask
	task automatic finish_test;
		if (fails == 0 && total_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic start_in(input int lo, hi, input logic x);
		int n;
		n = 0;
		while (n < hi + 20 && o_start_move !== 1'b1)
		begin
			@(posedge i_clock);
			#2;
			n++;
		end
		cmp_lvl(16'(x), 16'(n >= lo && n <= hi));
	endtask

	// ----------------------------------------------------------------
	// Answer monitor
	// ----------------------------------------------------------------
	always @(posedge i_clock)
	begin
		#2;
		if (o_rsp_valid === 1'b1)
		begin
			e = (i_acm_ctrl_model.exp_q.size() != 0) ? i_acm_ctrl_model.exp_q.pop_front()
				: 18'h2ffff;
			cmp_rsp(e, {e[17], o_rsp_error, e[17] ? o_rsp_data : e[15:0]});
		end
	end
	initial
	begin
		#2000000;
		fails++;
		finish_test;
	end

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial
	begin
		void'($urandom(10761));
		{fails, total_checks} = '0;
		cnt = '{default: 0};
		i_arst_n = 1'b0;
		i_evt = '0;
		{i_current_ma, i_switch_temp, i_run_status, pk_i} = '0;
		{i_body_temp, mn_t, pk_s} = {16'h7fff, 16'h7fff, 16'h0000};
		repeat (2) @(posedge i_clock);
		#1;
		i_arst_n = 1'b1;
		repeat (200)
		begin
			@(posedge i_clock);
			#1;
			i_evt = 10'($urandom);
			{i_current_ma, i_switch_temp} = $urandom;
			i_body_temp = 16'($urandom);
			for (int k = 0; k < 10; k++) cnt[k] += int'(i_evt[9-k]);
			if (i_current_ma > pk_i) pk_i = i_current_ma;
			if ($signed(i_switch_temp) > pk_s) pk_s = i_switch_temp;
			if ($signed(i_body_temp) < mn_t) mn_t = i_body_temp;
		end
		@(posedge i_clock);
		#1;
		i_evt = '0;
		foreach (pr[j])
			{ir[pr[j]], ir[pr[j]+1]} = cnt[j];
		{ir[34], ir[35], ir[36], ir[47]} = {pk_i, pk_s, mn_t, cnt[9][15:0]};
		for (int a = 26; a <= 47; a++)
			i_acm_ctrl_model.rd(1'b1, 16'(a), ir[a]);
		i_acm_ctrl_model.xfer(1'b1, 1'b1, 1'b0, 16'd27, 16'h0000, 1'b1, 1'b0, 16'h0000);
		i_acm_ctrl_model.rd(1'b1, 16'd27, ir[27]);
		i_acm_ctrl_model.xfer(1'b1, 1'b0, 1'b1, 16'd26, 16'h0000, 1'b0, 1'b0, 16'h0000);
		i_acm_ctrl_model.sched(16'h0123, 16'd0, 16'd0, 16'd5, 16'd0);
		i_acm_ctrl_model.rd(1'b1, `ACM_IR_RUN_STATUS, `ACM_RUN_STATUS_WAITING);
		cmp_lvl(16'h0123, o_target_pos);
		start_in(5 * SC - 11, 5 * SC - 5, 1'b1);
		i_acm_ctrl_model.rd(1'b1, `ACM_IR_RUN_STATUS, `ACM_RUN_STATUS_IDLE);
		i_acm_ctrl_model.sched(16'h0200, 16'd0, 16'd0, 16'd4, 16'd0);
		i_acm_ctrl_model.wr(`ACM_HR_REMOTE_COMMAND, `ACM_CMD_RUN_SCHEDULED);
		start_in(0, 4 * SC, 1'b0);
		i_acm_ctrl_model.sched(16'h0300, 16'd58, 16'd2, 16'd1, 16'd3);
		start_in(3 * SC - 9, 3 * SC - 3, 1'b1);
		for (int k = 0; k < 4; k++)
		begin
			i_run_status = 16'($urandom);
			i_acm_ctrl_model.wr(`ACM_HR_TARGET_POSITION, i_run_status);
			cmp_lvl(i_run_status, o_target_pos);
		end
		i_acm_ctrl_model.wr(`ACM_HR_IN_MAP_SELECT, 16'd74);
		i_acm_ctrl_model.rd(1'b0, `ACM_HR_IN_MAP_VALUE, 16'd74);
		for (int k = 0; k < 3; k++)
		begin
			i_acm_ctrl_model.wr(`ACM_HR_IN_MAP_SELECT, 16'(74 + k));
			i_acm_ctrl_model.wr(`ACM_HR_IN_MAP_VALUE, (k == 0) ? 16'd1 : 16'(31 + k));
		end
		i_acm_ctrl_model.rd(1'b1, 16'd74, i_run_status);
		i_acm_ctrl_model.rd(1'b1, 16'd75, ir[32]);
		i_acm_ctrl_model.rd(1'b1, 16'd76, ir[33]);
		i_acm_ctrl_model.wr(`ACM_HR_IN_MAP_SELECT, 16'd74);
		i_acm_ctrl_model.rd(1'b0, `ACM_HR_IN_MAP_VALUE, 16'd1);
		i_acm_ctrl_model.wr(`ACM_HR_IN_MAP_VALUE, 16'd34);
		i_acm_ctrl_model.rd(1'b1, 16'd74, ir[34]);
		i_acm_ctrl_model.xfer(1'b0, 1'b1, 1'b0, `ACM_HR_HOLD_MAP_SELECT, 16'd200, 1'b1, 1'b0,
			16'h0000);
		i_acm_ctrl_model.xfer(1'b0, 1'b1, 1'b0, `ACM_HR_HOLD_MAP_VALUE, 16'd1, 1'b1, 1'b0,
			16'h0000);
		i_acm_ctrl_model.wr(`ACM_HR_HOLD_MAP_SELECT, 16'd20);
		i_acm_ctrl_model.wr(`ACM_HR_HOLD_MAP_VALUE, 16'd1);
		i_acm_ctrl_model.rd(1'b0, `ACM_HR_HOLD_MAP_VALUE, 16'd1);
		i_acm_ctrl_model.wr(16'd20, 16'h0abc);
		cmp_lvl(16'h0abc, o_target_pos);
		i_acm_ctrl_model.wr(`ACM_HR_MAP_COMMAND, `ACM_MAP_CMD_SAVE);
		i_acm_ctrl_model.wr(`ACM_HR_MAP_COMMAND, `ACM_MAP_CMD_DEFAULT);
		i_acm_ctrl_model.rd(1'b1, 16'd74, 16'h0000);
		i_acm_ctrl_model.wr(16'd20, 16'h0555);
		cmp_lvl(16'h0abc, o_target_pos);
		i_acm_ctrl_model.xfer(1'b0, 1'b1, 1'b0, `ACM_HR_MAP_COMMAND, 16'd7, 1'b1, 1'b0,
			16'h0000);
		i_acm_ctrl_model.xfer(1'b0, 1'b0, 1'b0, 16'd200, 16'h0000, 1'b1, 1'b0, 16'h0000);
		repeat (3) @(posedge i_clock);
		cmp_lvl(16'h0000, 16'(i_acm_ctrl_model.exp_q.size()));
		finish_test;
	end
endmodule

bind acm_regs acm_regs_checker #(.MAP_DEPTH(MAP_DEPTH), .SEC_CYCLES(SEC_CYCLES))
	i_acm_regs_checker (.i_clock(i_clock), .i_arst_n(i_arst_n), .i_req_valid(i_req_valid),
	.i_req(i_req), .i_run_status(i_run_status), .o_rsp_valid(o_rsp_valid),
	.o_rsp_error(o_rsp_error), .o_rsp_data(o_rsp_data), .o_target_pos(o_target_pos),
	.o_cmd_strobe(o_cmd_strobe), .o_cmd_value(o_cmd_value), .o_start_move(o_start_move),
	.o_armed(o_armed), .o_map_save(o_map_save));
